// ===== tcpc_pkg.sv
// Constants, types and register map of the Type-C configuration channel port controller.
package tcpc_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
	localparam int unsigned CC_DB_MS    = 133;
	localparam int unsigned VB_DB_MS    = 2;
	localparam int unsigned TDRP_MS     = 75;
	localparam int unsigned SRC_PCT     = 30;
	localparam int unsigned CC_DB_CYC   = CC_DB_MS * CYC_PER_MS;
	localparam int unsigned VB_DB_CYC   = VB_DB_MS * CYC_PER_MS;
	localparam int unsigned TDRP_CYC    = TDRP_MS * CYC_PER_MS;
	localparam int unsigned SRC_CYC     = (TDRP_CYC * SRC_PCT) / 100;
	localparam int          CNT_W       = 24;
	localparam int          STRAP_W     = 2;
	localparam logic [1:0]  STRAP_DLY   = 2'h2;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int          ADDR_W      = 4;
	localparam logic [3:0]  STATUS_OFS  = 4'h0;
	localparam logic [3:0]  CTRL_OFS    = 4'h4;
	localparam logic        CTRL_RST    = 1'h1;
	localparam logic [1:0]  HTRANS_NSEQ = 2'h2;

	// ************************************************************
	// Pin codes
	// ************************************************************
	typedef enum logic [1:0] {
		TRI_LOW  = 2'h0,
		TRI_MID  = 2'h1,
		TRI_HIGH = 2'h2,
		TRI_BAD  = 2'h3
	} tcpc_tri_t;

	// CC comparator code; meaning depends on the termination presented.
	localparam logic [1:0] LVL_OPEN = 2'h0;
	localparam logic [1:0] LVL_RA   = 2'h1;
	localparam logic [1:0] LVL_RD   = 2'h2;
	localparam logic [1:0] LVL_DEF  = 2'h1;
	localparam logic [1:0] LVL_MED  = 2'h2;
	localparam logic [1:0] LVL_HIGH = 2'h3;

	localparam logic [1:0] ADV_DEF  = 2'h0;
	localparam logic [1:0] ADV_MED  = 2'h1;
	localparam logic [1:0] ADV_HIGH = 2'h2;

	typedef enum logic [2:0] {
		UNATT_SNK = 3'h0,
		ATTW_SNK  = 3'h1,
		ATT_SNK   = 3'h3,
		UNATT_SRC = 3'h2,
		ATTW_SRC  = 3'h6,
		ATT_SRC   = 3'h7
	} tcpc_state_t;

	typedef struct packed {
		logic pu1;
		logic pd1;
		logic pu2;
		logic pd2;
	} tcpc_term_t;

	// Open-drain pins; a set bit pulls the pin low.
	typedef struct packed {
		logic dir;
		logic attach;
		logic stat_a;
		logic stat_b;
	} tcpc_od_t;

	typedef struct packed {
		tcpc_tri_t  role;
		tcpc_tri_t  cur;
		logic [1:0] cc1;
		logic [1:0] cc2;
		logic       vbus;
		tcpc_od_t   od_in;
	} tcpc_pins_t;

endpackage : tcpc_pkg

// ===== tcpc_port_ctrl.sv
// Type-C configuration channel port controller with AHB-Lite status and control registers.
`timescale 1ns/10ps
module tcpc_port_ctrl
	import tcpc_pkg::*;
#(
	parameter int unsigned CC_DB = CC_DB_CYC,
	parameter int unsigned VB_DB = VB_DB_CYC,
	parameter int unsigned TDRP  = TDRP_CYC,
	parameter int unsigned TSRC  = SRC_CYC
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic [1:0]  role_strap_i,
	input  wire logic [1:0]  cur_strap_i,
	input  wire logic [1:0]  cc1_lvl_i,
	input  wire logic [1:0]  cc2_lvl_i,
	input  wire logic        bus_power_sense_i,
	input  wire tcpc_od_t    od_in_i,
	output tcpc_od_t         od_out_o,
	output tcpc_od_t         od_oe_o,
	output tcpc_term_t       term_o,
	output logic      [1:0]  adv_level_o,
	output logic             vconn_cc1_o,
	output logic             vconn_cc2_o
);

	localparam logic [CNT_W-1:0] CC_N   = CNT_W'(CC_DB);
	localparam logic [CNT_W-1:0] VB_N   = CNT_W'(VB_DB);
	localparam logic [CNT_W-1:0] TDRP_N = CNT_W'(TDRP - 1);
	localparam logic [CNT_W-1:0] SNK_N  = CNT_W'(TDRP - TSRC);

	// ************************************************************
	// Input synchronisers and strap capture
	// ************************************************************
	tcpc_pins_t       pin_s1;
	tcpc_pins_t       pin_s2;
	tcpc_tri_t        role;
	tcpc_tri_t        cur;
	logic [1:0]       strap_cnt;
	logic             strap_done;
	tcpc_tri_t        next_role;
	tcpc_tri_t        next_cur;
	logic [1:0]       next_strap_cnt;
	logic             next_strap_done;

	always_comb begin
		next_role       = role;
		next_cur        = cur;
		next_strap_cnt  = strap_cnt;
		next_strap_done = strap_done;
		// The straps are read once, after the synchronisers have filled.
		if (!strap_done) begin
			if (strap_cnt == STRAP_DLY) begin
				next_role       = pin_s2.role;
				next_cur        = pin_s2.cur;
				next_strap_done = 1'b1;
			end else begin
				next_strap_cnt = strap_cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		pin_s1 <= {tcpc_tri_t'(role_strap_i), tcpc_tri_t'(cur_strap_i), cc1_lvl_i, cc2_lvl_i,
			bus_power_sense_i, od_in_i};
		pin_s2 <= pin_s1;
		if (!rst_b_i) begin
			role       <= TRI_LOW;
			cur        <= TRI_LOW;
			strap_cnt  <= 2'h0;
			strap_done <= 1'b0;
		end else begin
			role       <= next_role;
			cur        <= next_cur;
			strap_cnt  <= next_strap_cnt;
			strap_done <= next_strap_done;
		end
	end

	// ************************************************************
	// Debounce and toggle counters
	// ************************************************************
	tcpc_state_t      state;
	logic [3:0]       cc_prev;
	logic [CNT_W-1:0] cc_cnt;
	logic [CNT_W-1:0] vb_cnt;
	logic [CNT_W-1:0] tog_cnt;
	logic [3:0]       next_cc_prev;
	logic [CNT_W-1:0] next_cc_cnt;
	logic [CNT_W-1:0] next_vb_cnt;
	logic [CNT_W-1:0] next_tog_cnt;
	logic             cc_stable;
	logic             vbus_ok;
	logic             present_src;
	logic             toggling;

	assign cc_stable   = (cc_cnt == CC_N);
	assign vbus_ok     = (vb_cnt == VB_N);
	assign toggling    = (role == TRI_MID) && (state == UNATT_SNK || state == UNATT_SRC);
	assign present_src = (tog_cnt >= SNK_N);

	always_comb begin
		next_cc_prev = {pin_s2.cc1, pin_s2.cc2};
		next_cc_cnt  = cc_cnt;
		next_vb_cnt  = vb_cnt;
		next_tog_cnt = 24'h000000;
		if (next_cc_prev != cc_prev) begin
			next_cc_cnt = 24'h000000;
		end else if (!cc_stable) begin
			next_cc_cnt = cc_cnt + 24'h000001;
		end
		if (!pin_s2.vbus) begin
			next_vb_cnt = 24'h000000;
		end else if (!vbus_ok) begin
			next_vb_cnt = vb_cnt + 24'h000001;
		end
		if (toggling && tog_cnt != TDRP_N) begin
			next_tog_cnt = tog_cnt + 24'h000001;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			cc_prev <= 4'h0;
			cc_cnt  <= 24'h000000;
			vb_cnt  <= 24'h000000;
			tog_cnt <= 24'h000000;
		end else begin
			cc_prev <= next_cc_prev;
			cc_cnt  <= next_cc_cnt;
			vb_cnt  <= next_vb_cnt;
			tog_cnt <= next_tog_cnt;
		end
	end

	// ************************************************************
	// Connection state machine and pin outputs
	// ************************************************************
	logic             ctrl_vconn;
	logic             orient;
	tcpc_state_t      next_state;
	logic             next_orient;
	tcpc_term_t       next_term;
	tcpc_od_t         next_od_oe;
	logic             next_vc1;
	logic             next_vc2;
	logic [1:0]       next_adv;
	logic             snk1;
	logic             snk2;
	logic             rd1;
	logic             rd2;
	logic             src_pres;
	logic [1:0]       act_lvl;
	tcpc_state_t      home;

	always_comb begin
		snk1        = (pin_s2.cc1 != LVL_OPEN);
		snk2        = (pin_s2.cc2 != LVL_OPEN);
		rd1         = (pin_s2.cc1 == LVL_RD);
		rd2         = (pin_s2.cc2 == LVL_RD);
		home        = (role == TRI_HIGH) ? UNATT_SRC : UNATT_SNK;
		next_state  = state;
		next_orient = orient;
		unique case (state)
			UNATT_SNK: begin
				if (!strap_done) begin
					next_state = UNATT_SNK;
				end else if (role == TRI_HIGH) begin
					next_state = UNATT_SRC;
				end else if (snk1 || snk2) begin
					next_state = ATTW_SNK;
				end else if (role == TRI_MID && present_src) begin
					next_state = UNATT_SRC;
				end
			end
			ATTW_SNK: begin
				if (!(snk1 || snk2)) begin
					next_state = home;
				end else if (cc_stable && vbus_ok) begin
					next_state  = ATT_SNK;
					next_orient = !snk1;
				end
			end
			ATT_SNK: begin
				if (!vbus_ok) begin
					next_state = home;
				end
			end
			UNATT_SRC: begin
				if (rd1 || rd2) begin
					next_state = ATTW_SRC;
				end else if (role == TRI_MID && !present_src) begin
					next_state = UNATT_SNK;
				end
			end
			ATTW_SRC: begin
				if (!(rd1 || rd2)) begin
					next_state = home;
				end else if (cc_stable) begin
					next_state  = ATT_SRC;
					next_orient = !rd1;
				end
			end
			ATT_SRC: begin
				if (!(orient ? rd2 : rd1)) begin
					next_state = home;
				end
			end
			default: begin
				next_state = UNATT_SNK;
			end
		endcase

		src_pres = (state == UNATT_SRC || state == ATTW_SRC || state == ATT_SRC);
		if (role == TRI_HIGH || (role == TRI_MID && src_pres)) begin
			next_term = '{pu1: 1'b1, pd1: 1'b0, pu2: 1'b1, pd2: 1'b0};
		end else begin
			next_term = '{pu1: 1'b0, pd1: 1'b1, pu2: 1'b0, pd2: 1'b1};
		end

		unique case (cur)
			TRI_MID:  next_adv = ADV_MED;
			TRI_HIGH: next_adv = ADV_HIGH;
			default:  next_adv = ADV_DEF;
		endcase

		// VCONN goes to the line that is not carrying CC, and only while Ra is seen there.
		next_vc1 = (state == ATT_SRC) && ctrl_vconn && orient && (pin_s2.cc1 == LVL_RA);
		next_vc2 = (state == ATT_SRC) && ctrl_vconn && !orient && (pin_s2.cc2 == LVL_RA);

		act_lvl    = orient ? pin_s2.cc2 : pin_s2.cc1;
		next_od_oe = '0;
		next_od_oe.attach = (state == ATT_SRC);
		next_od_oe.dir    = (state == ATT_SRC || state == ATT_SNK) && !orient;
		if (role == TRI_LOW || state == ATT_SNK) begin
			if (state == ATT_SNK) begin
				next_od_oe.stat_a = (act_lvl != LVL_DEF);
				next_od_oe.stat_b = (act_lvl != LVL_MED);
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			state       <= UNATT_SNK;
			orient      <= 1'b0;
			term_o      <= '{pu1: 1'b0, pd1: 1'b1, pu2: 1'b0, pd2: 1'b1};
			od_oe_o     <= '0;
			od_out_o    <= '0;
			adv_level_o <= ADV_DEF;
			vconn_cc1_o <= 1'b0;
			vconn_cc2_o <= 1'b0;
		end else begin
			state       <= next_state;
			orient      <= next_orient;
			term_o      <= next_term;
			od_oe_o     <= next_od_oe;
			od_out_o    <= '0;
			adv_level_o <= next_adv;
			vconn_cc1_o <= next_vc1;
			vconn_cc2_o <= next_vc2;
		end
	end

	// ************************************************************
	// AHB-Lite register slave
	// ************************************************************
	logic              wr_pend;
	logic [ADDR_W-1:0] wr_addr;
	logic              next_wr_pend;
	logic [ADDR_W-1:0] next_wr_addr;
	logic [31:0]       next_rdata;
	logic              next_ctrl_vconn;
	logic              ap_valid;

	// Zero wait states: read data is sampled in the address phase, so it is one cycle old.
	always_comb begin
		ap_valid        = hsel_i && hready_i && htrans_i[1];
		next_wr_pend    = ap_valid && hwrite_i;
		next_wr_addr    = haddr_i[ADDR_W-1:0];
		next_rdata      = hrdata_o;
		next_ctrl_vconn = ctrl_vconn;
		if (wr_pend && wr_addr == CTRL_OFS) begin
			next_ctrl_vconn = hwdata_i[0];
		end
		if (ap_valid && !hwrite_i) begin
			unique case (haddr_i[ADDR_W-1:0])
				STATUS_OFS: next_rdata = {18'h0, pin_s2.od_in, act_lvl, cc_stable, vbus_ok,
					orient, role, state};
				CTRL_OFS:   next_rdata = {31'h0, ctrl_vconn};
				default:    next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			wr_pend     <= 1'b0;
			wr_addr     <= '0;
			hrdata_o    <= 32'h00000000;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
			ctrl_vconn  <= CTRL_RST;
		end else begin
			wr_pend     <= next_wr_pend;
			wr_addr     <= next_wr_addr;
			hrdata_o    <= next_rdata;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
			ctrl_vconn  <= next_ctrl_vconn;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	sequence leave_src_s;
		state == ATT_SRC ##1 state != ATT_SRC;
	endsequence

	strap_hold_a: assert property (strap_done |=> $stable(role)) else $error("role changed");
	src_pullup_a: assert property (role == TRI_HIGH && $past(role) == TRI_HIGH |=>
		term_o.pu1 && term_o.pu2 && !term_o.pd1) else $error("source pull-ups missing");
	snk_pulldown_a: assert property (role == TRI_LOW && strap_done |=>
		term_o.pd1 && term_o.pd2 && !term_o.pu2) else $error("sink pull-downs missing");
	snk_attach_a: assert property (state != ATT_SNK ##1 state == ATT_SNK |->
		$past(vbus_ok) && $past(cc_stable)) else $error("sink attach without VBUS");
	tog_period_a: assert property (tog_cnt <= TDRP_N) else $error("toggle overrun");
	vconn_src_a: assert property (vconn_cc1_o || vconn_cc2_o |-> $past(state) == ATT_SRC)
		else $error("VCONN outside attached source");
	vconn_off_a: assert property (leave_src_s |=> !vconn_cc1_o && !vconn_cc2_o)
		else $error("VCONN left on after detach");
	src_flag_a: assert property (state == ATT_SRC |=> od_oe_o.attach) else $error("attach flag missing");
	vbus_drop_a: assert property (state == ATT_SNK && !vbus_ok |=> state != ATT_SNK)
		else $error("no detach on VBUS loss");
	stat_src_a: assert property (state == ATT_SRC |=> !od_oe_o.stat_a && !od_oe_o.stat_b)
		else $error("status pins driven as source");

endmodule : tcpc_port_ctrl

// ===== tcpc_partner.sv
// Behavioural far-side Type-C port that answers the terminations presented on CC.
`timescale 1ns/10ps
module tcpc_partner
	import tcpc_pkg::*;
(
	input  wire tcpc_term_t term_i,
	input  wire logic [1:0] mode_i,
	input  wire logic       flip_i,
	input  wire logic       ra_i,
	input  wire logic [1:0] adv_i,
	input  wire logic       vbus_en_i,
	output logic      [1:0] cc1_o,
	output logic      [1:0] cc2_o,
	output logic            vbus_o
);
	logic [1:0] act;
	logic [1:0] oth;

	// Mode 1 is a sink, mode 2 a source; a level only shows where the far termination lets it.
	always_comb begin
		act = LVL_OPEN;
		oth = LVL_OPEN;
		if (mode_i == 2'h1) begin
			if (flip_i ? term_i.pu2 : term_i.pu1) begin
				act = LVL_RD;
			end
			if (ra_i && (flip_i ? term_i.pu1 : term_i.pu2)) begin
				oth = LVL_RA;
			end
		end else if (mode_i == 2'h2) begin
			if (flip_i ? term_i.pd2 : term_i.pd1) begin
				act = adv_i;
			end
		end
		cc1_o = flip_i ? oth : act;
		cc2_o = flip_i ? act : oth;
	end

	assign vbus_o = (mode_i == 2'h2) && vbus_en_i;
endmodule : tcpc_partner

// ===== tcpc_port_ctrl_tb.sv
// Self-checking testbench of the Type-C port controller with a far-side partner model.
`timescale 1ns/10ps
module tcpc_port_ctrl_tb
	import tcpc_pkg::*;
;
	localparam int unsigned CCD = 40;
	localparam int unsigned TDP = 100;
	localparam int unsigned TSR = 30;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	tcpc_od_t    od_out;
	tcpc_tri_t   role = TRI_LOW;
	logic [1:0]  cur = 2'h0;
	logic [1:0]  cc1, cc2, mode = 2'h0, lvl = 2'h1;
	logic        vbus, flip = 1'b0, ra = 1'b0, vbus_en = 1'b0, vc1, vc2;
	tcpc_od_t    od_oe;
	tcpc_term_t  term;
	logic [1:0]  adv;
	logic [31:0] rd;
	int          seed = 11112;
	int          miscompares = 0;
	int          checks = 0;
	int          n;

	always #5 mclk = ~mclk;

	tcpc_port_ctrl #(.CC_DB(CCD), .VB_DB(10), .TDRP(TDP), .TSRC(TSR)) i_tcpc_port_ctrl (
		.mclk_i(mclk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
		.hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .role_strap_i(role),
		.cur_strap_i(cur), .cc1_lvl_i(cc1), .cc2_lvl_i(cc2), .bus_power_sense_i(vbus),
		.od_in_i(tcpc_od_t'(~od_oe)), .od_out_o(od_out), .od_oe_o(od_oe), .term_o(term),
		.adv_level_o(adv), .vconn_cc1_o(vc1), .vconn_cc2_o(vc2));

	tcpc_partner i_tcpc_partner (.term_i(term), .mode_i(mode), .flip_i(flip), .ra_i(ra),
		.adv_i(lvl), .vbus_en_i(vbus_en), .cc1_o(cc1), .cc2_o(cc2), .vbus_o(vbus));

	// ************************************************************
	// Tasks and expectations
	// ************************************************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NSEQ;
		hwrite <= wr;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : ahb

	// Polls STATUS so the bus is exercised while the port walks its states.
	task wait_st(input logic [2:0] st);
		int k;
		k = 0;
		ahb(1'b0, 32'h0, 32'h0);
		while (rd[2:0] !== st && k < 400) begin
			ahb(1'b0, 32'h0, 32'h0);
			k++;
		end
		repeat (3) @(posedge mclk);
		chk({29'h0, rd[2:0]}, {29'h0, st});
	endtask : wait_st

	task do_reset(input tcpc_tri_t r);
		@(posedge mclk);
		role <= r;
		mode <= 2'h0;
		rst_b <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (5) @(posedge mclk);
	endtask : do_reset

	function automatic logic [1:0] exp_stat(input logic [1:0] l);
		exp_stat = (l == LVL_DEF) ? 2'h1 : (l == LVL_MED) ? 2'h2 : 2'h3;
	endfunction : exp_stat

	function automatic logic [1:0] exp_adv(input logic [1:0] c);
		exp_adv = (c == 2'h1) ? ADV_MED : (c == 2'h2) ? ADV_HIGH : ADV_DEF;
	endfunction : exp_adv

	task stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (5) @(posedge mclk);
		ahb(1'b0, 32'h0, 32'h0);
		chk({29'h0, rd[2:0]}, {29'h0, UNATT_SNK});
		chk({28'h0, term}, 32'h5);
		ahb(1'b0, {28'h0, CTRL_OFS}, 32'h0);
		chk(rd, {31'h0, CTRL_RST});
		ahb(1'b1, {28'h0, CTRL_OFS}, 32'h0);
		ahb(1'b0, {28'h0, CTRL_OFS}, 32'h0);
		chk(rd, 32'h0);
		ahb(1'b1, {28'h0, CTRL_OFS}, 32'h1);
		ahb(1'b1, 32'h8, $random(seed));
		ahb(1'b0, 32'h8, 32'h0);
		chk(rd, 32'h0);
		role <= TRI_HIGH;
		repeat (10) @(posedge mclk);
		chk({28'h0, term}, 32'h5);
		role <= TRI_LOW;
		$display("test reset done");
		for (int i = 1; i < 4; i++) begin
			lvl <= 2'(i);
			flip <= 1'($random(seed));
			cur <= 2'($random(seed));
			mode <= 2'h2;
			wait_st(ATTW_SNK);
			repeat (3 * CCD) @(posedge mclk);
			wait_st(ATTW_SNK);
			vbus_en <= 1'b1;
			wait_st(ATT_SNK);
			chk({30'h0, od_oe.stat_a, od_oe.stat_b}, {30'h0, exp_stat(lvl)});
			chk({31'h0, od_oe.dir}, {31'h0, ~flip});
			// The partner still shows its pull-up, so losing VBUS sends the port home to UNATT_SNK and it re-enters the wait state.
			vbus_en <= 1'b0;
			wait_st(ATTW_SNK);
			chk({30'h0, od_oe.stat_a, od_oe.stat_b}, 32'h0);
			mode <= 2'h0;
			wait_st(UNATT_SNK);
		end
		$display("test sink done");
		// The current strap is captured with the role strap, so each level needs its own reset.
		for (int c = 0; c < 4; c++) begin
			cur <= 2'(c);
			do_reset(TRI_HIGH);
			chk({30'h0, adv}, {30'h0, exp_adv(2'(c))});
		end
		chk({28'h0, term}, 32'hA);
		flip <= 1'($random(seed));
		ra <= 1'b1;
		mode <= 2'h1;
		wait_st(ATT_SRC);
		chk({30'h0, vc1, vc2}, flip ? 32'h2 : 32'h1);
		chk({31'h0, od_oe.attach}, 32'h1);
		chk({30'h0, od_oe.stat_a, od_oe.stat_b}, 32'h0);
		chk({31'h0, od_oe.dir}, {31'h0, ~flip});
		chk({28'h0, od_out}, 32'h0);
		mode <= 2'h0;
		wait_st(UNATT_SRC);
		chk({30'h0, vc1, vc2}, 32'h0);
		$display("test source done");
		do_reset(TRI_MID);
		n = 0;
		repeat (TDP) begin
			@(posedge mclk);
			n += int'(term.pu1);
		end
		chk(n, TSR);
		ra <= 1'b0;
		mode <= 2'h1;
		wait_st(ATT_SRC);
		chk({30'h0, vc1, vc2}, 32'h0);
		chk({30'h0, od_oe.stat_a, od_oe.stat_b}, 32'h0);
		$display("test dual role done");
		stop_test();
	end

	// The longest scenario stays well below this span, so reaching it means a hang.
	initial begin
		repeat (60000) @(posedge mclk);
		miscompares++;
		$display("watchdog expired at %0t", $time);
		stop_test();
	end
endmodule : tcpc_port_ctrl_tb
